// *** hdl/pcs_mgmt_pkg.sv ***
// Shared constants for the coding sublayer management register bank
package pcs_mgmt_pkg;

  // ----------------------------------------------------------------
  // Host bus byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] HOST_CTRL_LO    = 6'h00;
  localparam logic [5:0] HOST_CTRL_HI    = 6'h01;
  localparam logic [5:0] HOST_STAT_LO    = 6'h02;
  localparam logic [5:0] HOST_STAT_HI    = 6'h03;
  localparam logic [5:0] HOST_ADV_LO     = 6'h08;
  localparam logic [5:0] HOST_ADV_HI     = 6'h09;
  localparam logic [5:0] HOST_PARTNER_LO = 6'h0A;
  localparam logic [5:0] HOST_PARTNER_HI = 6'h0B;
  localparam logic [5:0] HOST_EXPAN_LO   = 6'h0C;
  localparam logic [5:0] HOST_EXPAN_HI   = 6'h0D;
  localparam logic [5:0] HOST_EXTSTAT_LO = 6'h1E;
  localparam logic [5:0] HOST_EXTSTAT_HI = 6'h1F;

  // ----------------------------------------------------------------
  // Serial management register numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] MGMT_CTRL    = 5'h00;
  localparam logic [4:0] MGMT_STAT    = 5'h01;
  localparam logic [4:0] MGMT_ADV     = 5'h04;
  localparam logic [4:0] MGMT_PARTNER = 5'h05;
  localparam logic [4:0] MGMT_EXPAN   = 5'h06;
  localparam logic [4:0] MGMT_EXTSTAT = 5'h0F;

  // ----------------------------------------------------------------
  // Control word bit positions (16-bit view, high byte = bits 15:8)
  // ----------------------------------------------------------------
  localparam int CTRL_RESET_BIT    = 15;
  localparam int CTRL_LOOPBACK_BIT = 14;
  localparam int CTRL_SPEED0_BIT   = 13;
  localparam int CTRL_ANEN_BIT     = 12;
  localparam int CTRL_PDOWN_BIT    = 11;
  localparam int CTRL_ISOLATE_BIT  = 10;
  localparam int CTRL_RESTART_BIT  = 9;
  localparam int CTRL_DUPLEX_BIT   = 8;
  localparam int CTRL_SPEED1_BIT   = 6;
  localparam int CTRL_UNIDIR_BIT   = 5;

  // ----------------------------------------------------------------
  // Status, expansion and ability bit positions
  // ----------------------------------------------------------------
  localparam int STAT_EXTSTAT_BIT  = 8;
  localparam int STAT_UNICAP_BIT   = 7;
  localparam int STAT_ANDONE_BIT   = 5;
  localparam int STAT_ANABLE_BIT   = 3;
  localparam int STAT_LINK_BIT     = 2;
  localparam int EXPAN_PAGE_BIT    = 1;
  localparam int ADV_SPEED_LSB     = 10;

  // ----------------------------------------------------------------
  // Speed codes and constant words
  // ----------------------------------------------------------------
  localparam logic [1:0]  SPEED_RSVD = 2'h3;
  localparam logic [1:0]  SPEED_1G   = 2'h2;
  localparam logic [1:0]  SPEED_100M = 2'h1;
  localparam logic [1:0]  SPEED_10M  = 2'h0;
  localparam logic [15:0] EXTSTAT_WORD = 16'h8000;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_SPEED    = 2'h2;
  localparam logic        RST_ANEN     = 1'b1;
  localparam logic        RST_DUPLEX   = 1'b1;
  localparam logic [15:0] RST_ADV      = 16'h0001;

endpackage

// *** hdl/sticky_read_flag.sv ***
// Status flag that latches one level and is released by a read
`timescale 1ns/1ps
module sticky_read_flag #(
  parameter logic LATCH_VAL = 1'b1,
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic latchEvent,
  input  wire logic liveValue,
  input  wire logic readStrobe,
  output logic      flag
);

  logic flag_q;

  // An event in the read cycle wins, so it is never lost
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= RESET_VAL;
    end else if (latchEvent) begin
      flag_q <= LATCH_VAL;
    end else if (readStrobe) begin
      flag_q <= liveValue;
    end
  end

  assign flag = flag_q;

endmodule

// *** hdl/speed_resolver.sv ***
// Chooses the (G)MII data rate from mode, negotiation and control fields
`timescale 1ns/1ps
module speed_resolver (
  input  wire logic       plainGigabitMode,
  input  wire logic       anEnable,
  input  wire logic [1:0] speedSel,
  input  wire logic [1:0] advSpeed,
  output logic      [1:0] gmiiRate
);

  always_comb begin
    if (plainGigabitMode) begin
      gmiiRate = pcs_mgmt_pkg::SPEED_1G;
    end else if (anEnable) begin
      gmiiRate = advSpeed;
    end else begin
      gmiiRate = speedSel;
    end
  end

endmodule

// *** hdl/pcs_management_registers.sv ***
// Management register bank: host byte bus and serial management word view
`timescale 1ns/1ps
// Notes on behaviour
// - Page received latches, clears when read
// - Extended status constant: bit 15 only set
// - Word registers as low/high byte pairs
// - Control reset bit pulses then self clears
// - Loopback bit readable and writable
// - Speed code: 10=1G, 01=100M, 00=10M
// - Plain gigabit mode fixes speed at 10
// - Speed bits steer rate only without negotiation
// - With negotiation, rate from advertised bits 11:10
// - Speed LSB high bit5, MSB low bit6
// - Power down bit readable and writable
// - Restart negotiation bit pulses then clears
// - Duplex bit stored only, no effect
// - Link status latches low until read
module pcs_management_registers #(
  parameter bit PLAIN_GIGABIT_MODE = 1'b0,
  parameter bit UNIDIR_CAPABLE     = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [5:0]  hostAddr,
  input  wire logic [7:0]  hostWrData,
  input  wire logic        hostWrEn,
  input  wire logic        hostRdEn,
  output logic      [7:0]  hostRdData,
  input  wire logic [4:0]  mgmtAddr,
  input  wire logic [15:0] mgmtWrData,
  input  wire logic        mgmtWrEn,
  input  wire logic        mgmtRdEn,
  output logic      [15:0] mgmtRdData,
  input  wire logic        pageReceived,
  input  wire logic        linkUp,
  input  wire logic        anComplete,
  input  wire logic [15:0] partnerAbility,
  output logic             coreReset,
  output logic             anRestart,
  output logic             loopbackEn,
  output logic             powerDown,
  output logic             isolate,
  output logic             anEnable,
  output logic             duplexFull,
  output logic             unidirEn,
  output logic      [1:0]  gmiiRate,
  output logic      [15:0] advAbility
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PLAIN_GIGABIT_MODE !== 1'b0 && PLAIN_GIGABIT_MODE !== 1'b1) begin : g_bad_mode
    $error("PLAIN_GIGABIT_MODE must be 0 or 1");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        resetBit_q;
  logic        restartBit_q;
  logic        loopback_q;
  logic [1:0]  speedSel_q;
  logic        anEnable_q;
  logic        powerDown_q;
  logic        isolate_q;
  logic        duplex_q;
  logic        unidir_q;
  logic [15:0] adv_q;
  logic [7:0]  hostRdData_q;
  logic [15:0] mgmtRdData_q;

  // ----------------------------------------------------------------
  // Write decode: both views funnel into one word with byte enables
  // ----------------------------------------------------------------
  logic        ctrlWrLo;
  logic        ctrlWrHi;
  logic        advWrLo;
  logic        advWrHi;
  logic [15:0] wrWord;

  // Host access takes priority if both buses write in the same cycle
  always_comb begin
    ctrlWrLo = 1'b0;
    ctrlWrHi = 1'b0;
    advWrLo  = 1'b0;
    advWrHi  = 1'b0;
    wrWord   = mgmtWrData;
    if (hostWrEn) begin
      wrWord = {hostWrData, hostWrData};
      case (hostAddr)
        pcs_mgmt_pkg::HOST_CTRL_LO: begin
          ctrlWrLo = 1'b1;
        end
        pcs_mgmt_pkg::HOST_CTRL_HI: begin
          ctrlWrHi = 1'b1;
        end
        pcs_mgmt_pkg::HOST_ADV_LO: begin
          advWrLo = 1'b1;
        end
        pcs_mgmt_pkg::HOST_ADV_HI: begin
          advWrHi = 1'b1;
        end
        default: begin
          ctrlWrLo = 1'b0;
        end
      endcase
    end else if (mgmtWrEn) begin
      case (mgmtAddr)
        pcs_mgmt_pkg::MGMT_CTRL: begin
          ctrlWrLo = 1'b1;
          ctrlWrHi = 1'b1;
        end
        pcs_mgmt_pkg::MGMT_ADV: begin
          advWrLo = 1'b1;
          advWrHi = 1'b1;
        end
        default: begin
          ctrlWrLo = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Self-clearing command bits
  // ----------------------------------------------------------------
  // Each stands for exactly one cycle, so the pulse doubles as the command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetBit_q   <= 1'b0;
      restartBit_q <= 1'b0;
    end else begin
      resetBit_q   <= ctrlWrHi & wrWord[pcs_mgmt_pkg::CTRL_RESET_BIT];
      restartBit_q <= ctrlWrHi & wrWord[pcs_mgmt_pkg::CTRL_RESTART_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Control high byte fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loopback_q  <= 1'b0;
      anEnable_q  <= pcs_mgmt_pkg::RST_ANEN;
      powerDown_q <= 1'b0;
      isolate_q   <= 1'b0;
      duplex_q    <= pcs_mgmt_pkg::RST_DUPLEX;
    end else if (ctrlWrHi) begin
      loopback_q  <= wrWord[pcs_mgmt_pkg::CTRL_LOOPBACK_BIT];
      anEnable_q  <= wrWord[pcs_mgmt_pkg::CTRL_ANEN_BIT];
      powerDown_q <= wrWord[pcs_mgmt_pkg::CTRL_PDOWN_BIT];
      isolate_q   <= wrWord[pcs_mgmt_pkg::CTRL_ISOLATE_BIT];
      duplex_q    <= wrWord[pcs_mgmt_pkg::CTRL_DUPLEX_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Control low byte fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unidir_q <= 1'b0;
    end else if (ctrlWrLo) begin
      unidir_q <= wrWord[pcs_mgmt_pkg::CTRL_UNIDIR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Speed selection, split over both control bytes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      speedSel_q <= pcs_mgmt_pkg::RST_SPEED;
    end else if (PLAIN_GIGABIT_MODE) begin
      speedSel_q <= pcs_mgmt_pkg::SPEED_1G;
    end else begin
      if (ctrlWrHi) begin
        speedSel_q[0] <= wrWord[pcs_mgmt_pkg::CTRL_SPEED0_BIT];
      end
      if (ctrlWrLo) begin
        speedSel_q[1] <= wrWord[pcs_mgmt_pkg::CTRL_SPEED1_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Advertised ability
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_q <= pcs_mgmt_pkg::RST_ADV;
    end else begin
      if (advWrLo) begin
        adv_q[7:0] <= wrWord[7:0];
      end
      if (advWrHi) begin
        adv_q[15:8] <= wrWord[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read strobes that carry side effects
  // ----------------------------------------------------------------
  logic statRead;
  logic expanRead;
  logic linkFlag;
  logic pageFlag;

  assign statRead  = (hostRdEn && hostAddr == pcs_mgmt_pkg::HOST_STAT_LO)
                   || (mgmtRdEn && mgmtAddr == pcs_mgmt_pkg::MGMT_STAT);
  assign expanRead = (hostRdEn && hostAddr == pcs_mgmt_pkg::HOST_EXPAN_LO)
                   || (mgmtRdEn && mgmtAddr == pcs_mgmt_pkg::MGMT_EXPAN);

  sticky_read_flag #(
    .LATCH_VAL (1'b0),
    .RESET_VAL (1'b0)
  ) u_link_flag (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .latchEvent (~linkUp),
    .liveValue  (linkUp),
    .readStrobe (statRead),
    .flag       (linkFlag)
  );

  sticky_read_flag #(
    .LATCH_VAL (1'b1),
    .RESET_VAL (1'b0)
  ) u_page_flag (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .latchEvent (pageReceived),
    .liveValue  (1'b0),
    .readStrobe (expanRead),
    .flag       (pageFlag)
  );

  // ----------------------------------------------------------------
  // Register words as seen by both views
  // ----------------------------------------------------------------
  logic [15:0] ctrlWord;
  logic [15:0] statWord;
  logic [15:0] expanWord;

  // Collision test and the low reserved bits are simply never stored
  always_comb begin
    ctrlWord = 16'h0000;
    ctrlWord[pcs_mgmt_pkg::CTRL_RESET_BIT]    = resetBit_q;
    ctrlWord[pcs_mgmt_pkg::CTRL_LOOPBACK_BIT] = loopback_q;
    ctrlWord[pcs_mgmt_pkg::CTRL_SPEED0_BIT]   = speedSel_q[0];
    ctrlWord[pcs_mgmt_pkg::CTRL_ANEN_BIT]     = anEnable_q;
    ctrlWord[pcs_mgmt_pkg::CTRL_PDOWN_BIT]    = powerDown_q;
    ctrlWord[pcs_mgmt_pkg::CTRL_ISOLATE_BIT]  = isolate_q;
    ctrlWord[pcs_mgmt_pkg::CTRL_RESTART_BIT]  = restartBit_q;
    ctrlWord[pcs_mgmt_pkg::CTRL_DUPLEX_BIT]   = duplex_q;
    ctrlWord[pcs_mgmt_pkg::CTRL_SPEED1_BIT]   = speedSel_q[1];
    ctrlWord[pcs_mgmt_pkg::CTRL_UNIDIR_BIT]   = unidir_q;
  end

  always_comb begin
    statWord = 16'h0000;
    statWord[pcs_mgmt_pkg::STAT_EXTSTAT_BIT] = 1'b1;
    statWord[pcs_mgmt_pkg::STAT_UNICAP_BIT]  = UNIDIR_CAPABLE;
    statWord[pcs_mgmt_pkg::STAT_ANDONE_BIT]  = anComplete;
    statWord[pcs_mgmt_pkg::STAT_ANABLE_BIT]  = 1'b1;
    statWord[pcs_mgmt_pkg::STAT_LINK_BIT]    = linkFlag;
  end

  always_comb begin
    expanWord = 16'h0000;
    expanWord[pcs_mgmt_pkg::EXPAN_PAGE_BIT] = pageFlag;
  end

  // ----------------------------------------------------------------
  // Host byte read port, one cycle of latency
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hostRdData_q <= 8'h00;
    end else if (hostRdEn) begin
      case (hostAddr)
        pcs_mgmt_pkg::HOST_CTRL_LO:    hostRdData_q <= ctrlWord[7:0];
        pcs_mgmt_pkg::HOST_CTRL_HI:    hostRdData_q <= ctrlWord[15:8];
        pcs_mgmt_pkg::HOST_STAT_LO:    hostRdData_q <= statWord[7:0];
        pcs_mgmt_pkg::HOST_STAT_HI:    hostRdData_q <= statWord[15:8];
        pcs_mgmt_pkg::HOST_ADV_LO:     hostRdData_q <= adv_q[7:0];
        pcs_mgmt_pkg::HOST_ADV_HI:     hostRdData_q <= adv_q[15:8];
        pcs_mgmt_pkg::HOST_PARTNER_LO: hostRdData_q <= partnerAbility[7:0];
        pcs_mgmt_pkg::HOST_PARTNER_HI: hostRdData_q <= partnerAbility[15:8];
        pcs_mgmt_pkg::HOST_EXPAN_LO:   hostRdData_q <= expanWord[7:0];
        pcs_mgmt_pkg::HOST_EXPAN_HI:   hostRdData_q <= expanWord[15:8];
        pcs_mgmt_pkg::HOST_EXTSTAT_LO: hostRdData_q <= pcs_mgmt_pkg::EXTSTAT_WORD[7:0];
        pcs_mgmt_pkg::HOST_EXTSTAT_HI: hostRdData_q <= pcs_mgmt_pkg::EXTSTAT_WORD[15:8];
        default:                       hostRdData_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial management word read port, one cycle of latency
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmtRdData_q <= 16'h0000;
    end else if (mgmtRdEn) begin
      case (mgmtAddr)
        pcs_mgmt_pkg::MGMT_CTRL:    mgmtRdData_q <= ctrlWord;
        pcs_mgmt_pkg::MGMT_STAT:    mgmtRdData_q <= statWord;
        pcs_mgmt_pkg::MGMT_ADV:     mgmtRdData_q <= adv_q;
        pcs_mgmt_pkg::MGMT_PARTNER: mgmtRdData_q <= partnerAbility;
        pcs_mgmt_pkg::MGMT_EXPAN:   mgmtRdData_q <= expanWord;
        pcs_mgmt_pkg::MGMT_EXTSTAT: mgmtRdData_q <= pcs_mgmt_pkg::EXTSTAT_WORD;
        default:                    mgmtRdData_q <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data rate selection
  // ----------------------------------------------------------------
  logic [1:0] rateSel;

  speed_resolver u_speed (
    .plainGigabitMode (PLAIN_GIGABIT_MODE),
    .anEnable         (anEnable_q),
    .speedSel         (speedSel_q),
    .advSpeed         (adv_q[pcs_mgmt_pkg::ADV_SPEED_LSB +: 2]),
    .gmiiRate         (rateSel)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Duplex only reaches a port for visibility; the channel ignores it
  assign hostRdData = hostRdData_q;
  assign mgmtRdData = mgmtRdData_q;
  assign coreReset  = resetBit_q;
  assign anRestart  = restartBit_q;
  assign loopbackEn = loopback_q;
  assign powerDown  = powerDown_q;
  assign isolate    = isolate_q;
  assign anEnable   = anEnable_q;
  assign duplexFull = duplex_q;
  assign unidirEn   = unidir_q;
  assign gmiiRate   = rateSel;
  assign advAbility = adv_q;

endmodule

// *** tb/pcs_mgmt_sva.sv ***
// Concurrent checks on the management register bank ports
`timescale 1ns/1ps
module pcs_mgmt_sva #(
  parameter bit PLAIN_GIGABIT_MODE = 1'b0
) (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [5:0]  hostAddr,
  input wire logic [7:0]  hostWrData,
  input wire logic        hostWrEn,
  input wire logic        hostRdEn,
  input wire logic [7:0]  hostRdData,
  input wire logic [4:0]  mgmtAddr,
  input wire logic        mgmtRdEn,
  input wire logic [15:0] mgmtRdData,
  input wire logic        pageReceived,
  input wire logic        linkUp,
  input wire logic        coreReset,
  input wire logic        anRestart,
  input wire logic        loopbackEn,
  input wire logic        powerDown,
  input wire logic        isolate,
  input wire logic        anEnable,
  input wire logic        unidirEn,
  input wire logic [1:0]  gmiiRate,
  input wire logic [15:0] advAbility
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic wrHi;
  logic wrLo;
  assign wrHi = hostWrEn && hostAddr == 6'h01;
  assign wrLo = hostWrEn && hostAddr == 6'h00;
  chk_reset_pulse: assert property (wrHi && hostWrData[7] |=> coreReset ##1 !coreReset)
    else $error("core reset pulse wrong");
  chk_restart_pulse: assert property (wrHi && hostWrData[1] |=> anRestart ##1 !anRestart)
    else $error("restart pulse wrong");
  chk_loop_write: assert property (wrHi |=> loopbackEn == $past(hostWrData[6]))
    else $error("loopback not written");
  chk_power_write: assert property (wrHi |=> powerDown == $past(hostWrData[3]))
    else $error("power down not written");
  chk_isolate_write: assert property (wrHi |=> isolate == $past(hostWrData[2]))
    else $error("isolate not written");
  chk_unidir_write: assert property (wrLo |=> unidirEn == $past(hostWrData[5]))
    else $error("unidirectional not written");
  chk_rate_source: assert property (PLAIN_GIGABIT_MODE ? gmiiRate == 2'h2 :
    (!anEnable || gmiiRate == advAbility[11:10])) else $error("rate source wrong");
  chk_extstat_read: assert property (mgmtRdEn && mgmtAddr == 5'h0F
    |=> mgmtRdData == 16'h8000) else $error("extended status wrong");
  chk_ctrl_lo_zero: assert property (hostRdEn && hostAddr == 6'h00
    |=> hostRdData[7] == 1'b0 && hostRdData[4:0] == 5'h00) else $error("stuck bits set");
  chk_page_read: assert property (pageReceived ##[1:2] (hostRdEn && hostAddr == 6'h0C)
    |=> hostRdData[1]) else $error("page flag lost");
  chk_link_latch: assert property (!linkUp ##[1:2] (hostRdEn && hostAddr == 6'h02)
    |=> !hostRdData[2]) else $error("link drop not latched");
endmodule

bind pcs_management_registers pcs_mgmt_sva #(.PLAIN_GIGABIT_MODE(PLAIN_GIGABIT_MODE))
  pcs_mgmt_sva_inst (.core_clk, .rst_b, .hostAddr, .hostWrData, .hostWrEn, .hostRdEn,
  .hostRdData, .mgmtAddr, .mgmtRdEn, .mgmtRdData, .pageReceived, .linkUp, .coreReset,
  .anRestart, .loopbackEn, .powerDown, .isolate, .anEnable, .unidirEn, .gmiiRate, .advAbility);

// *** tb/host_bus_model.sv ***
// Management controller model driving the host byte bus and word port
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        core_clk,
  input  wire logic [7:0]  hostRdData,
  input  wire logic [15:0] mgmtRdData,
  output logic      [5:0]  hostAddr,
  output logic      [7:0]  hostWrData,
  output logic             hostWrEn,
  output logic             hostRdEn,
  output logic      [4:0]  mgmtAddr,
  output logic      [15:0] mgmtWrData,
  output logic             mgmtWrEn,
  output logic             mgmtRdEn
);
  initial begin
    hostAddr = 6'h00;
    hostWrData = 8'h00;
    hostWrEn = 1'b0;
    hostRdEn = 1'b0;
    mgmtAddr = 5'h00;
    mgmtWrData = 16'h0000;
    mgmtWrEn = 1'b0;
    mgmtRdEn = 1'b0;
  end
  // Released data is inverted so a stale byte can never look valid
  task automatic hostWrite(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hostAddr <= a;
    hostWrData <= d;
    hostWrEn <= 1'b1;
    @(posedge core_clk);
    hostWrEn <= 1'b0;
    hostWrData <= ~d;
    #1;
  endtask
  task automatic hostRead(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    hostAddr <= a;
    hostRdEn <= 1'b1;
    @(posedge core_clk);
    hostRdEn <= 1'b0;
    #1;
    d = hostRdData;
  endtask
  task automatic mgmtWrite(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    mgmtAddr <= a;
    mgmtWrData <= d;
    mgmtWrEn <= 1'b1;
    @(posedge core_clk);
    mgmtWrEn <= 1'b0;
    mgmtWrData <= ~d;
  endtask
  task automatic mgmtRead(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    mgmtAddr <= a;
    mgmtRdEn <= 1'b1;
    @(posedge core_clk);
    mgmtRdEn <= 1'b0;
    #1;
    d = mgmtRdData;
  endtask
endmodule

// *** tb/pcs_management_registers_tb.sv ***
// Self-checking bench for the management register bank
`timescale 1ns/1ps
module pcs_management_registers_tb;
  logic        core_clk, rst_b, hostWrEn, hostRdEn, mgmtWrEn, mgmtRdEn;
  logic        pageReceived, linkUp, anComplete, coreReset, anRestart;
  logic        loopbackEn, powerDown, isolate, anEnable, duplexFull, unidirEn;
  logic [5:0]  hostAddr;
  logic [4:0]  mgmtAddr;
  logic [7:0]  hostWrData, hostRdData, rdG, rd;
  logic [15:0] mgmtWrData, mgmtRdData, partnerAbility, advAbility, wd;
  logic [1:0]  gmiiRate, rateG, sp;
  int          n_mismatch, comparisons, cycles;
  logic [5:0]  mapAddr [13] = '{6'h01, 6'h00, 6'h02, 6'h03, 6'h08, 6'h09, 6'h0A, 6'h0B,
                                6'h0C, 6'h0D, 6'h1E, 6'h1F, 6'h05};
  logic [7:0]  mapExp [13] = '{8'h11, 8'h40, 8'h88, 8'h01, 8'h01, 8'h00, 8'hC3, 8'hA5,
                               8'h00, 8'h00, 8'h00, 8'h80, 8'h00};

  pcs_management_registers pcs_management_registers_inst (.core_clk, .rst_b, .hostAddr,
    .hostWrData, .hostWrEn, .hostRdEn, .hostRdData, .mgmtAddr, .mgmtWrData, .mgmtWrEn,
    .mgmtRdEn, .mgmtRdData, .pageReceived, .linkUp, .anComplete, .partnerAbility,
    .coreReset, .anRestart, .loopbackEn, .powerDown, .isolate, .anEnable, .duplexFull,
    .unidirEn, .gmiiRate, .advAbility);
  // Second bank in plain gigabit mode sees the same traffic
  pcs_management_registers #(.PLAIN_GIGABIT_MODE(1'b1)) pcs_management_registers_plain_inst (
    .core_clk, .rst_b, .hostAddr, .hostWrData, .hostWrEn, .hostRdEn, .hostRdData(rdG),
    .mgmtAddr, .mgmtWrData, .mgmtWrEn, .mgmtRdEn, .mgmtRdData(), .pageReceived, .linkUp,
    .anComplete, .partnerAbility, .coreReset(), .anRestart(), .loopbackEn(), .powerDown(),
    .isolate(), .anEnable(), .duplexFull(), .unidirEn(), .gmiiRate(rateG), .advAbility());
  host_bus_model host_bus_model_inst (.core_clk, .hostRdData, .mgmtRdData, .hostAddr,
    .hostWrData, .hostWrEn, .hostRdEn, .mgmtAddr, .mgmtWrData, .mgmtWrEn, .mgmtRdEn);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    pageReceived = 1'b0;
    linkUp = 1'b0;
    anComplete = 1'b0;
    partnerAbility = 16'hA5C3;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      host_bus_model_inst.hostRead(mapAddr[i], rd);
      check("map read", mapExp[i], rd);
    end
    host_bus_model_inst.hostWrite(6'h1F, 8'h00);
    host_bus_model_inst.hostRead(6'h1F, rd);
    check("extstat hi", 8'h80, rd);
    host_bus_model_inst.mgmtRead(5'h0F, wd);
    check("extstat word", 16'h8000, wd);
    $display("map test done");
    host_bus_model_inst.hostWrite(6'h00, 8'hFF);
    host_bus_model_inst.hostRead(6'h00, rd);
    check("ctrl lo", 8'h60, rd);
    check("plain ctrl lo", 8'h60, rdG);
    check("unidir", 1'b1, unidirEn);
    host_bus_model_inst.hostWrite(6'h01, 8'h4D);
    check("loopback", 1'b1, loopbackEn);
    check("power", 1'b1, powerDown);
    check("isolate", 1'b1, isolate);
    check("duplex", 1'b1, duplexFull);
    check("an off", 1'b0, anEnable);
    host_bus_model_inst.hostRead(6'h01, rd);
    check("ctrl hi", 8'h4D, rd);
    host_bus_model_inst.hostWrite(6'h01, 8'h00);
    host_bus_model_inst.hostRead(6'h01, rd);
    check("ctrl hi clear", 8'h00, rd);
    check("duplex off", 1'b0, duplexFull);
    check("rate 1G", 2'h2, gmiiRate);
    $display("control bits test done");
    host_bus_model_inst.hostWrite(6'h01, 8'h82);
    check("reset pulse", 1'b1, coreReset);
    check("restart pulse", 1'b1, anRestart);
    @(posedge core_clk);
    #1;
    check("reset clear", 1'b0, coreReset);
    check("restart clear", 1'b0, anRestart);
    host_bus_model_inst.hostRead(6'h01, rd);
    check("self clear", 8'h00, rd);
    $display("self clear test done");
    for (int c = 0; c < 4; c++) begin
      sp = 2'(c);
      host_bus_model_inst.hostWrite(6'h00, {1'b0, sp[1], 6'h00});
      host_bus_model_inst.hostWrite(6'h01, {2'b00, sp[0], 5'h00});
      host_bus_model_inst.hostRead(6'h00, rd);
      check("speed lo", {1'b0, sp[1], 6'h00}, rd);
      check("plain speed lo", 8'h40, rdG);
      host_bus_model_inst.hostRead(6'h01, rd);
      check("speed hi", {2'b00, sp[0], 5'h00}, rd);
      check("plain speed hi", 8'h00, rdG);
      check("plain rate", 2'h2, rateG);
      if (sp != 2'h3) begin
        check("rate", sp, gmiiRate);
      end
    end
    host_bus_model_inst.hostWrite(6'h01, 8'h10);
    for (int c = 0; c < 3; c++) begin
      sp = 2'(c);
      host_bus_model_inst.hostWrite(6'h09, {4'h0, sp, 2'b00});
      check("adv rate", sp, gmiiRate);
    end
    host_bus_model_inst.hostWrite(6'h01, 8'h30);
    check("speed ignored", 2'h2, gmiiRate);
    $display("speed test done");
    host_bus_model_inst.mgmtWrite(5'h04, 16'h1234);
    host_bus_model_inst.hostRead(6'h08, rd);
    check("adv lo", 8'h34, rd);
    check("adv", 16'h1234, advAbility);
    host_bus_model_inst.hostRead(6'h09, rd);
    check("adv hi", 8'h12, rd);
    @(posedge core_clk);
    pageReceived <= 1'b1;
    @(posedge core_clk);
    pageReceived <= 1'b0;
    host_bus_model_inst.hostRead(6'h0C, rd);
    check("page set", 8'h02, rd);
    host_bus_model_inst.hostRead(6'h0C, rd);
    check("page cleared", 8'h00, rd);
    $display("page test done");
    @(posedge core_clk);
    linkUp <= 1'b1;
    anComplete <= 1'b1;
    host_bus_model_inst.hostRead(6'h02, rd);
    check("link latched", 8'hA8, rd);
    host_bus_model_inst.hostRead(6'h02, rd);
    check("link up", 8'hAC, rd);
    @(posedge core_clk);
    linkUp <= 1'b0;
    @(posedge core_clk);
    linkUp <= 1'b1;
    host_bus_model_inst.hostRead(6'h02, rd);
    check("link drop", 8'hA8, rd);
    host_bus_model_inst.hostRead(6'h02, rd);
    check("link back", 8'hAC, rd);
    $display("link test done");
    end_of_test();
  end
endmodule
